//--- design/lcdcd_top.sv
// lcdcd_top: serial bus slave, command and data decoder of the lcd controller
// How it works
// RULE_01: command byte 001xxxxx loads seg flip, com flip, sleep, walk, bank
// RULE_02: seg flip and com flip reverse segment and common scan order
// RULE_03: sleep grounds outputs, stops bias, drive generator and oscillator
// RULE_04: in sleep the ram keeps its contents and still takes data writes
// RULE_05: walk bit 0 is horizontal addressing, 1 is vertical
// RULE_06: display control, page and column set only act in basic bank
// RULE_07: bank 1 decodes command bytes with the extended set
// RULE_08: data writes and function set work in either bank
// RULE_09: status read gives sleep,0,0,d,e,seg flip,com flip,bit order
// RULE_10: mode 00 blank, 01 all on, 10 normal, 11 inverse
// RULE_11: bit order 0 puts msb on top row, 1 puts lsb on top
// RULE_12: data byte is stored at current column and page
// RULE_13: each data write in horizontal walk advances the column by one
// RULE_14: column wraps to 0 after the last column is written
// RULE_15: basic command 0000010x sets drive span select from bit 0
// RULE_16: columns run 0 to 101; out of range column sets are ignored
// RULE_17: pages run 0 to 9; out of range page sets are ignored
// RULE_18: charge pump is off when drive level and span select are zero
// RULE_19: vertical walk advances page, then column past last page, both wrap
module lcdcd_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // serial bus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // decoder stall from the drain side
  input wire logic DECODE_HOLD,
  // display scan port
  input wire logic [6:0] SCAN_COL,
  input wire logic [3:0] SCAN_PAGE,
  output logic [7:0] SCAN_DATA,
  // settings
  output logic SEG_FLIP,
  output logic COM_FLIP,
  output logic SLEEP_FLAG,
  output logic ADDR_WALK,
  output logic CMD_BANK,
  output logic [1:0] DISP_MODE,
  output logic BIT_ORDER,
  output logic DRIVE_SPAN_SEL,
  output logic [6:0] DRIVE_LEVEL,
  output logic [2:0] BIAS_SEL,
  // power control
  output logic PUMP_ON,
  output logic BIAS_GEN_ON,
  output logic OSC_ON,
  output logic OUTPUTS_GND,
  // address state
  output logic [6:0] COL_ADDR,
  output logic [3:0] PAGE_ADDR
);
  // ****************************************
  // functions
  // ****************************************
  function automatic logic [lcdcd_pkg::RAM_AW-1:0] ram_index(input logic [3:0] pg,
                                                             input logic [6:0] col);
    ram_index = 10'(10'(pg) * lcdcd_pkg::COLS_PER_PAGE + 10'(col));
  endfunction : ram_index

  function automatic logic [7:0] bit_rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      bit_rev[i] = v[7-i];
    end
  endfunction : bit_rev

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic scl_m_reg, scl_s_reg, scl_d_reg;
  logic sda_m_reg, sda_s_reg, sda_d_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      {scl_m_reg, scl_s_reg, scl_d_reg} <= 3'h7;
      {sda_m_reg, sda_s_reg, sda_d_reg} <= 3'h7;
    end else begin
      {scl_m_reg, scl_s_reg, scl_d_reg} <= {SCL_IN, scl_m_reg, scl_s_reg};
      {sda_m_reg, sda_s_reg, sda_d_reg} <= {SDA_IN, sda_m_reg, sda_s_reg};
    end
  end
  wire scl_rise = scl_s_reg & ~scl_d_reg;
  wire scl_fall = ~scl_s_reg & scl_d_reg;
  wire bus_start = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  wire bus_stop = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;

  // ****************************************
  // settings state
  // ****************************************
  lcdcd_pkg::lcdcd_func_t func_reg, func_next;
  logic [1:0] mode_reg, mode_next;
  logic order_reg, order_next;
  logic span_reg, span_next;
  logic [6:0] level_reg, level_next;
  logic [2:0] bias_reg, bias_next;
  logic [6:0] col_reg, col_next;
  logic [3:0] page_reg, page_next;
  // status byte: sleep, two zeros, d, e, seg flip, com flip, bit order
  wire [7:0] status_w = {func_reg.sleep_flag, 2'h0, mode_reg, func_reg.seg_flip,
                         func_reg.com_flip, order_reg}; // RULE_09

  // ****************************************
  // serial bus slave
  // ****************************************
  lcdcd_pkg::lcdcd_bus_st_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic oe_reg, oe_next;
  logic rw_reg, rw_next;
  logic first_reg, first_next;
  logic sel_reg, sel_next;
  logic nack_reg, nack_next;
  logic push;
  logic fifo_in_ready;
  wire byte_done = scl_fall & (cnt_reg == lcdcd_pkg::BITS_PER_BYTE);
  wire [7:0] sh_in = {sh_reg[6:0], sda_s_reg};

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    sel_next = sel_reg;
    nack_next = nack_reg;
    push = 1'b0;
    if (bus_start) begin
      st_next = lcdcd_pkg::I_ADDR;
      cnt_next = 4'h0;
      oe_next = 1'b0;
      first_next = 1'b1;
    end else if (bus_stop) begin
      st_next = lcdcd_pkg::I_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        lcdcd_pkg::I_IDLE: begin
          oe_next = 1'b0;
        end
        lcdcd_pkg::I_ADDR, lcdcd_pkg::I_RX: begin
          if (scl_rise) begin
            sh_next = sh_in;
            cnt_next = 4'(cnt_reg + 4'h1);
          end else if (byte_done) begin
            st_next = lcdcd_pkg::I_ACK;
            if (st_reg == lcdcd_pkg::I_ADDR) begin
              oe_next = (sh_reg[7:1] == lcdcd_pkg::BUS_ADDR);
              rw_next = sh_reg[0];
              if (sh_reg[7:1] != lcdcd_pkg::BUS_ADDR) begin
                st_next = lcdcd_pkg::I_IDLE;
              end
            end else if (first_reg) begin
              // control byte picks command or data for the rest of the transfer
              sel_next = sh_reg[lcdcd_pkg::CTRL_SEL_BIT];
              first_next = 1'b0;
              oe_next = 1'b1;
            end else begin
              // full fifo: byte refused with a not-acknowledge
              push = fifo_in_ready;
              oe_next = fifo_in_ready;
            end
          end
        end
        lcdcd_pkg::I_ACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            oe_next = 1'b0;
            st_next = lcdcd_pkg::I_RX;
            if (rw_reg) begin
              sh_next = status_w; // RULE_09
              oe_next = ~status_w[7];
              cnt_next = 4'h1;
              st_next = lcdcd_pkg::I_TX;
            end
          end
        end
        lcdcd_pkg::I_TX: begin
          if (byte_done) begin
            oe_next = 1'b0;
            st_next = lcdcd_pkg::I_TACK;
          end else if (scl_fall) begin
            oe_next = ~sh_reg[6];
            sh_next = {sh_reg[6:0], 1'b0};
            cnt_next = 4'(cnt_reg + 4'h1);
          end
        end
        lcdcd_pkg::I_TACK: begin
          if (scl_rise) begin
            nack_next = sda_s_reg;
          end else if (scl_fall) begin
            st_next = nack_reg ? lcdcd_pkg::I_IDLE : lcdcd_pkg::I_TX;
            sh_next = status_w;
            oe_next = ~nack_reg & ~status_w[7];
            cnt_next = 4'h1;
          end
        end
        default: begin
          st_next = lcdcd_pkg::I_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= lcdcd_pkg::I_IDLE;
      {sh_reg, cnt_reg, oe_reg, rw_reg, first_reg, sel_reg, nack_reg} <= '0;
    end else begin
      st_reg <= st_next;
      {sh_reg, cnt_reg, oe_reg, rw_reg} <= {sh_next, cnt_next, oe_next, rw_next};
      {first_reg, sel_reg, nack_reg} <= {first_next, sel_next, nack_next};
    end
  end

  // ****************************************
  // byte fifo
  // ****************************************
  lcdcd_pkg::lcdcd_entry_t ent;
  logic fifo_out_valid;
  wire fifo_out_ready = ~DECODE_HOLD;
  lcdcd_fifo #(.WIDTH(lcdcd_pkg::FIFO_WIDTH), .DEPTH(lcdcd_pkg::FIFO_DEPTH)) u_fifo (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({sel_reg, sh_reg}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(ent)
  );

  // ****************************************
  // command decode
  // ****************************************
  wire pop = fifo_out_valid & fifo_out_ready;
  wire [7:0] b = ent.data;
  wire is_data = pop & ent.sel; // RULE_08
  wire is_cmd = pop & ~ent.sel;
  wire c_fset = is_cmd & (b[7:5] == 3'h1); // RULE_01 RULE_08
  wire basic = is_cmd & ~func_reg.cmd_bank; // RULE_06
  wire ext = is_cmd & func_reg.cmd_bank; // RULE_07
  wire c_range = basic & (b[7:1] == 7'h02); // RULE_15
  wire c_disp = basic & (b[7:3] == 5'h01) & ~b[1];
  wire c_page = basic & (b[7:4] == 4'h4) & (b[3:0] <= lcdcd_pkg::PAGE_LAST); // RULE_17
  wire c_col = basic & b[7] & (b[6:0] <= lcdcd_pkg::COL_LAST); // RULE_16
  wire c_order = ext & (b[7:3] == 5'h01);
  wire c_bias = ext & (b[7:3] == 5'h02);
  wire c_level = ext & b[7];
  wire col_end = (col_reg == lcdcd_pkg::COL_LAST);
  wire page_end = (page_reg == lcdcd_pkg::PAGE_LAST);
  wire [6:0] col_inc = col_end ? 7'h00 : 7'(col_reg + 7'h01); // RULE_13 RULE_14
  wire [3:0] page_inc = page_end ? 4'h0 : 4'(page_reg + 4'h1); // RULE_19

  always_comb begin
    func_next = c_fset ? lcdcd_pkg::lcdcd_func_t'(b[4:0]) : func_reg; // RULE_01
    mode_next = c_disp ? {b[2], b[0]} : mode_reg; // RULE_10
    order_next = c_order ? b[2] : order_reg;
    span_next = c_range ? b[0] : span_reg; // RULE_15
    level_next = c_level ? b[6:0] : level_reg;
    bias_next = c_bias ? b[2:0] : bias_reg;
    col_next = c_col ? b[6:0] : col_reg;
    page_next = c_page ? b[3:0] : page_reg;
    if (is_data) begin
      if (func_reg.addr_walk) begin
        page_next = page_inc; // RULE_05 RULE_19
        col_next = page_end ? col_inc : col_reg;
      end else begin
        col_next = col_inc; // RULE_05 RULE_13 RULE_14
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      func_reg <= '{seg_flip: 1'b0, com_flip: 1'b0, sleep_flag: lcdcd_pkg::SLEEP_RST,
                    addr_walk: 1'b0, cmd_bank: 1'b0};
      mode_reg <= lcdcd_pkg::MODE_BLANK;
      {order_reg, span_reg, level_reg, col_reg, page_reg} <= '0;
      bias_reg <= lcdcd_pkg::BIAS_RST;
    end else begin
      {func_reg, mode_reg, order_reg, span_reg} <= {func_next, mode_next, order_next, span_next};
      {level_reg, bias_reg, col_reg, page_reg} <= {level_next, bias_next, col_next, page_next};
    end
  end

  // ****************************************
  // display ram and scan path
  // ****************************************
  // scan mirrors in the address so the ram image stays in host order
  wire [6:0] scan_col_m = func_reg.seg_flip ? 7'(lcdcd_pkg::COL_LAST - SCAN_COL) : SCAN_COL; // RULE_02
  wire [3:0] scan_pg_m = func_reg.com_flip ? 4'(lcdcd_pkg::PAGE_LAST - SCAN_PAGE) : SCAN_PAGE; // RULE_02
  logic [7:0] ram_rd;
  lcdcd_ram u_ram (
    .clk(CLK),
    .we(is_data), // RULE_04 RULE_12
    .waddr(ram_index(page_reg, col_reg)),
    .wdata(b),
    .raddr(ram_index(scan_pg_m, scan_col_m)),
    .rdata(ram_rd)
  );
  wire [7:0] ram_ord = order_reg ? bit_rev(ram_rd) : ram_rd; // RULE_11
  wire [7:0] pix_w = (mode_reg == lcdcd_pkg::MODE_BLANK) ? 8'h00 :
                     (mode_reg == lcdcd_pkg::MODE_ALL_ON) ? 8'hff :
                     (mode_reg == lcdcd_pkg::MODE_INVERSE) ? ~ram_ord : ram_ord; // RULE_10
  wire pump_next = ~func_next.sleep_flag & ((level_next != 7'h00) | span_next); // RULE_18

  // ****************************************
  // output registers
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SCAN_DATA <= 8'h00;
      {PUMP_ON, BIAS_GEN_ON, OSC_ON, OUTPUTS_GND} <= 4'h1;
      {SDA_OUT, SDA_OE} <= 2'h0;
    end else begin
      SCAN_DATA <= func_reg.sleep_flag ? 8'h00 : pix_w; // RULE_03
      PUMP_ON <= pump_next; // RULE_03 RULE_18
      BIAS_GEN_ON <= ~func_next.sleep_flag; // RULE_03
      OSC_ON <= ~func_next.sleep_flag; // RULE_03
      OUTPUTS_GND <= func_next.sleep_flag; // RULE_03
      SDA_OUT <= 1'b0;
      SDA_OE <= oe_next;
    end
  end
  assign SEG_FLIP = func_reg.seg_flip;
  assign COM_FLIP = func_reg.com_flip;
  assign SLEEP_FLAG = func_reg.sleep_flag;
  assign ADDR_WALK = func_reg.addr_walk;
  assign CMD_BANK = func_reg.cmd_bank;
  assign DISP_MODE = mode_reg;
  assign BIT_ORDER = order_reg;
  assign DRIVE_SPAN_SEL = span_reg;
  assign DRIVE_LEVEL = level_reg;
  assign BIAS_SEL = bias_reg;
  assign COL_ADDR = col_reg;
  assign PAGE_ADDR = page_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire horiz_wr = is_data & ~func_reg.addr_walk;
  wire vert_wr = is_data & func_reg.addr_walk;

  fset_load_a: assert property (c_fset |=> func_reg == $past(b[4:0])) // RULE_01
    else $error("function set not loaded");
  sleep_power_a: assert property (OUTPUTS_GND |-> !PUMP_ON && !OSC_ON && !BIAS_GEN_ON) // RULE_03
    else $error("power left on in sleep");
  col_step_a: assert property (horiz_wr && !col_end |=> col_reg == $past(col_reg) + 7'h01) // RULE_13
    else $error("column not advanced");
  col_wrap_a: assert property (horiz_wr && col_end |=> col_reg == 7'h00 ##1 1'b1) // RULE_14
    else $error("column not wrapped");
  ext_bank_a: assert property (ext && b[7] |=> $stable(col_reg) && DRIVE_LEVEL == $past(b[6:0])) // RULE_06
    else $error("basic command run in extended bank");
  vert_walk_a: assert property (vert_wr && !page_end |=> $stable(col_reg) && page_reg == $past(page_inc)) // RULE_19
    else $error("vertical walk wrong");
  span_set_a: assert property (c_range |=> DRIVE_SPAN_SEL == $past(b[0])) // RULE_15
    else $error("span select not set");
  pump_zero_a: assert property (DRIVE_LEVEL == 7'h00 && !DRIVE_SPAN_SEL |-> !PUMP_ON) // RULE_18
    else $error("pump on with zero drive");
  status_load_a: assert property (st_reg == lcdcd_pkg::I_ACK && rw_reg && scl_fall |=> sh_reg[6:5] == 2'h0 && sh_reg[7] == $past(func_reg.sleep_flag)) // RULE_09
    else $error("status byte wrong");
  data_wr_c: cover property (is_data ##[1:20] is_data);
  wrap_c: cover property (horiz_wr && col_end);
  status_rd_c: cover property (st_reg == lcdcd_pkg::I_TX ##[1:400] st_reg == lcdcd_pkg::I_TACK);
endmodule : lcdcd_top

//--- design/lcdcd_pkg.sv
// lcdcd_pkg: constants and types shared by the lcd command decoder files
package lcdcd_pkg;
  // ****************************************
  // serial bus
  // ****************************************
  // slave address is arbitrary, not a value of any real part
  localparam logic [6:0] BUS_ADDR = 7'h3c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CTRL_SEL_BIT = 6;
  // ****************************************
  // display ram geometry
  // ****************************************
  localparam logic [6:0] COL_LAST = 7'h65;
  localparam logic [3:0] PAGE_LAST = 4'h9;
  localparam logic [9:0] COLS_PER_PAGE = 10'h066;
  localparam int RAM_WORDS = 1024;
  localparam int RAM_AW = 10;
  // ****************************************
  // buffering
  // ****************************************
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 9;
  // ****************************************
  // display modes (d,e) and reset values
  // ****************************************
  localparam logic [1:0] MODE_BLANK = 2'h0;
  localparam logic [1:0] MODE_ALL_ON = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h2;
  localparam logic [1:0] MODE_INVERSE = 2'h3;
  localparam logic SLEEP_RST = 1'h1;
  localparam logic [2:0] BIAS_RST = 3'h0;
  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic sel;
    logic [7:0] data;
  } lcdcd_entry_t;
  typedef struct packed {
    logic seg_flip;
    logic com_flip;
    logic sleep_flag;
    logic addr_walk;
    logic cmd_bank;
  } lcdcd_func_t;
  typedef enum logic [6:0] {
    I_IDLE = 7'b0000001,
    I_ADDR = 7'b0000010,
    I_ACK = 7'b0000100,
    I_RX = 7'b0001000,
    I_TX = 7'b0010000,
    I_TACK = 7'b0100000,
    I_SPARE = 7'b1000000
  } lcdcd_bus_st_t;
endpackage : lcdcd_pkg

//--- design/lcdcd_fifo.sv
// lcdcd_fifo: small valid/ready fifo between the serial receiver and the decoder
module lcdcd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem_reg[rd_reg];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= do_wr ? AW'(wr_reg + 1'b1) : wr_reg;
      rd_reg <= do_rd ? AW'(rd_reg + 1'b1) : rd_reg;
      cnt_reg <= (AW+1)'(cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
    end
  end
endmodule : lcdcd_fifo

//--- design/lcdcd_ram.sv
// lcdcd_ram: display ram, one write port and one registered read port
module lcdcd_ram (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [lcdcd_pkg::RAM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [lcdcd_pkg::RAM_AW-1:0] raddr,
  output logic [7:0] rdata
);
  // no reset: contents are kept across sleep and are undefined at power up
  logic [7:0] mem_reg [lcdcd_pkg::RAM_WORDS];

  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end
endmodule : lcdcd_ram

//--- bench/lcdcd_host.sv
// lcdcd_host: behavioural serial bus master for the decoder's bus pins
module lcdcd_host (
  // bus pins
  output logic scl,
  output logic sda_drv,
  input wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // bus cycles
  // ****************************************
  // sda_drv high means released; the wire then floats to its pull-up
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end
  task automatic start();
    sda_drv = 1'h1;
    #50 scl = 1'h1;
    #100 sda_drv = 1'h0;
    #100 scl = 1'h0;
  endtask : start
  // eight bits msb first, then the acknowledge slot; all steps are whole clock cycles
  task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                         output logic ack_out);
    logic [8:0] v;
    logic [8:0] got;
    v = {tx, ack_in};
    for (int i = 8; i >= 0; i--) begin
      #50 sda_drv = v[i];
      #50 scl = 1'h1;
      #50 got[i] = sda_wire;
      #50 scl = 1'h0;
    end
    rx = got[8:1];
    ack_out = got[0];
  endtask : byte_io
  // scl stands still high after the stop
  task automatic stop();
    #50 sda_drv = 1'h0;
    #50 scl = 1'h1;
    #100 sda_drv = 1'h1;
    #50;
  endtask : stop
endmodule : lcdcd_host

//--- bench/test_lcdcd_top.sv
// test_lcdcd_top: self-checking bench for the lcd command decoder
module test_lcdcd_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // wiring
  // ****************************************
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic hold = 1'h0;
  logic [6:0] scol = 7'h05;
  logic [3:0] spage = 4'h2;
  logic scl, sda_drv, sda_out, sda_oe, column_output, com, slp, walk, bank, bord, span, pump, bgen, osc;
  logic gnd;
  logic [7:0] sdat;
  logic [1:0] mode;
  logic [6:0] lvl, col;
  logic [2:0] bias;
  logic [3:0] page;
  int mismatches = 0;
  int num_checks = 0;
  // open drain: low while the device pulls, else the master's level
  wire sda = sda_oe ? 1'h0 : sda_drv;
  always #12.5 clk = ~clk;
  lcdcd_host host (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda));
  lcdcd_top DUT (.CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .DECODE_HOLD(hold), .SCAN_COL(scol), .SCAN_PAGE(spage), .SCAN_DATA(sdat),
    .SEG_FLIP(column_output), .COM_FLIP(com), .SLEEP_FLAG(slp), .ADDR_WALK(walk), .CMD_BANK(bank),
    .DISP_MODE(mode), .BIT_ORDER(bord), .DRIVE_SPAN_SEL(span), .DRIVE_LEVEL(lvl),
    .BIAS_SEL(bias), .PUMP_ON(pump), .BIAS_GEN_ON(bgen), .OSC_ON(osc), .OUTPUTS_GND(gnd),
    .COL_ADDR(col), .PAGE_ADDR(page));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic open_xfer(input logic rw, input logic sel);
    logic [7:0] rx;
    logic ack;
    @(posedge clk);
    #1;
    host.start();
    host.byte_io({lcdcd_pkg::BUS_ADDR, rw}, 1'h1, rx, ack);
    if (!rw) host.byte_io({1'h0, sel, 6'h00}, 1'h1, rx, ack);
  endtask : open_xfer
  task automatic wr(input logic sel, input logic [7:0] b);
    logic [7:0] rx;
    logic ack;
    open_xfer(1'h0, sel);
    host.byte_io(b, 1'h1, rx, ack);
    chk("byte ack", 8'h00, {7'h00, ack});
    host.stop();
    repeat (4) @(posedge clk);
    #1;
  endtask : wr
  task automatic status(input logic [7:0] exp);
    logic [7:0] rx;
    logic ack;
    open_xfer(1'h1, 1'h0);
    host.byte_io(8'hff, 1'h1, rx, ack);
    host.stop();
    chk("status", exp, rx);
  endtask : status
  // scan data lags the position by two cycles
  task automatic scan(input logic [7:0] exp);
    repeat (3) @(posedge clk);
    #1;
    chk("scan", exp, sdat);
  endtask : scan
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_func();
    chk("reset power", 8'h02, {3'h0, sda_out, osc, bgen, gnd, pump});
    wr(1'h0, 8'h38);
    chk("func bits", 8'h18, {3'h0, column_output, com, slp, walk, bank});
    chk("awake power", 8'h0c, {4'h0, osc, bgen, gnd, pump});
    status(8'h06);
    wr(1'h0, 8'h20);
    $display("t_func done");
  endtask : t_func
  task automatic t_modes();
    logic [7:0] px [4];
    px = '{8'h00, 8'hff, 8'h31, 8'hce};
    wr(1'h0, 8'h42);
    wr(1'h0, 8'h85);
    wr(1'h1, 8'h31);
    chk("col", 8'h06, {1'h0, col});
    for (int m = 0; m < 4; m++) begin
      wr(1'h0, {5'h01, m[1], 1'h0, m[0]});
      chk("mode", m[7:0], {6'h00, mode});
      scan(px[m]);
      status({3'h0, m[1:0], 3'h0});
    end
    wr(1'h0, 8'h0c);
    scol = 7'h60;
    spage = 4'h7;
    wr(1'h0, 8'h38);
    scan(8'h31);
    wr(1'h0, 8'h20);
    scol = 7'h05;
    spage = 4'h2;
    $display("t_modes done");
  endtask : t_modes
  task automatic t_walk();
    wr(1'h0, 8'he4);
    repeat (3) wr(1'h1, 8'h11);
    chk("wrap col", 8'h01, {1'h0, col});
    wr(1'h0, 8'h22);
    wr(1'h0, 8'h48);
    wr(1'h0, 8'h87);
    wr(1'h1, 8'h12);
    chk("vert step", 8'h97, {page, col[3:0]});
    wr(1'h1, 8'h12);
    chk("vert addr", 8'h08, {page, col[3:0]});
    wr(1'h0, 8'h20);
    wr(1'h1, 8'h13);
    chk("horiz addr", 8'h09, {page, col[3:0]});
    $display("t_walk done");
  endtask : t_walk
  task automatic t_bank();
    wr(1'h0, 8'h21);
    wr(1'h0, 8'h8a);
    chk("level", 8'h0a, {1'h0, lvl});
    chk("col kept", 8'h09, {1'h0, col});
    wr(1'h0, 8'h13);
    chk("bias", 8'h03, {5'h00, bias});
    wr(1'h0, 8'h0c);
    wr(1'h1, 8'h14);
    chk("order col", 8'h8a, {bord, col});
    wr(1'h0, 8'h20);
    wr(1'h0, 8'h8b);
    chk("basic col", 8'h0b, {1'h0, col});
    chk("level kept", 8'h0a, {1'h0, lvl});
    chk("pump", 8'h01, {7'h00, pump});
    scan(8'h8c);
    $display("t_bank done");
  endtask : t_bank
  task automatic t_range();
    wr(1'h0, 8'h21);
    wr(1'h0, 8'h80);
    chk("pump off", 8'h00, {7'h00, pump});
    wr(1'h0, 8'h20);
    wr(1'h0, 8'h05);
    chk("span high", 8'h03, {6'h00, span, pump});
    wr(1'h0, 8'h04);
    chk("span low", 8'h00, {6'h00, span, pump});
    $display("t_range done");
  endtask : t_range
  task automatic t_fifo();
    logic [7:0] rx;
    logic ack;
    wr(1'h0, 8'h43);
    wr(1'h0, 8'h80);
    wr(1'h0, 8'h4a);
    wr(1'h0, 8'he6);
    chk("page kept", 8'h03, {4'h0, page});
    chk("col range", 8'h00, {1'h0, col});
    hold = 1'h1;
    open_xfer(1'h0, 1'h1);
    for (int i = 0; i < 9; i++) begin
      host.byte_io(8'h40, 1'h1, rx, ack);
      chk("fifo ack", (i < 8) ? 8'h00 : 8'h01, {7'h00, ack});
    end
    host.stop();
    @(posedge clk);
    #1 hold = 1'h0;
    repeat (12) @(posedge clk);
    #1;
    chk("fifo col", 8'h08, {1'h0, col});
    $display("t_fifo done");
  endtask : t_fifo
  task automatic t_sleep();
    wr(1'h0, 8'h24);
    chk("sleep power", 8'h02, {4'h0, osc, bgen, gnd, pump});
    scan(8'h00);
    status(8'h91);
    wr(1'h1, 8'h77);
    chk("sleep col", 8'h09, {1'h0, col});
    wr(1'h0, 8'h20);
    scol = 7'h08;
    spage = 4'h3;
    scan(8'hee);
    $display("t_sleep done");
  endtask : t_sleep
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // ****************************************
  // sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_n = 1'h1;
    repeat (3) @(posedge clk);
    t_func();
    t_modes();
    t_walk();
    t_bank();
    t_range();
    t_fifo();
    t_sleep();
    end_sim();
  end
  initial begin
    #1_000_000;
    mismatches++;
    end_sim();
  end
endmodule : test_lcdcd_top
